// ### rtl/fcd_host.sv
// Host controller that issues flash command sequences over a parallel bus.
`timescale 1ns/100ps

module fcd_host #(
  parameter int unsigned ADD_GAP_CYC = fcd_pkg::ADD_GAP_CYC
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             req_valid,
  input  wire fcd_pkg::fcd_req_t req,
  output      logic             req_ready,
  output      logic             done,
  output      logic             err,
  output      logic [7:0]       rdata,
  output      fcd_pkg::fcd_pins_t pins,
  input  wire logic [7:0]       data_in,
  input  wire logic             port_c_line_three
);
  typedef enum {S_IDLE, S_SETUP, S_STRB, S_HOLD, S_SETTLE, S_WRDY, S_DONE} fcd_state_t;

  fcd_state_t         state_reg;
  fcd_pkg::fcd_req_t  rq_reg;
  logic [2:0]         step_reg;
  logic [3:0]         cnt_reg;
  logic [7:0]         mask_reg;
  fcd_pkg::fcd_step_t st;
  logic [7:0]         cur_sel;
  fcd_pkg::fcd_pins_t pins_next;

  // ---------------------------------------------------------------
  // Sequence tables
  // ---------------------------------------------------------------
  function automatic logic [7:0] lowbit(input logic [7:0] m);
    return m & (~m + 8'h01);
  endfunction

  function automatic logic [2:0] last_idx(input fcd_pkg::fcd_cmd_t c);
    unique case (c)
      fcd_pkg::CMD_ID, fcd_pkg::CMD_PROT:         return 3'h4;
      fcd_pkg::CMD_PROG:                          return 3'h3;
      fcd_pkg::CMD_SERASE, fcd_pkg::CMD_BERASE:   return 3'h5;
      fcd_pkg::CMD_BYP_ENTER:                     return 3'h2;
      fcd_pkg::CMD_BYP_PROG, fcd_pkg::CMD_BYP_EXIT: return 3'h1;
      default:                                    return 3'h0;
    endcase
  endfunction

  function automatic logic refused(input fcd_pkg::fcd_req_t r);
    logic no_sel;
    no_sel = r.arr ? (r.sel[3:0] == 4'h0) : (r.sel == 8'h00);
    return (r.cmd == fcd_pkg::CMD_ID && r.arr) || no_sel;
  endfunction

  function automatic logic waits(input fcd_pkg::fcd_cmd_t c);
    return c inside {fcd_pkg::CMD_PROG, fcd_pkg::CMD_SERASE, fcd_pkg::CMD_BERASE,
                     fcd_pkg::CMD_BYP_PROG, fcd_pkg::CMD_SUSP};
  endfunction

  function automatic fcd_pkg::fcd_step_t fstep(input fcd_pkg::fcd_req_t r,
                                               input logic [2:0] i);
    fcd_pkg::fcd_step_t s;
    logic [3:0]         hi;
    hi = r.addr[15:12];
    s  = '{rd: 1'b0, a: r.addr, d: r.data};
    unique case (r.cmd)
      fcd_pkg::CMD_READ:     s.rd = 1'b1;
      fcd_pkg::CMD_SUSP:     s.d = fcd_pkg::D_SUSP;
      fcd_pkg::CMD_RESUME:   s.d = fcd_pkg::D_SECT;
      fcd_pkg::CMD_RESET:    s.d = fcd_pkg::D_RESET;
      fcd_pkg::CMD_BYP_PROG: if (i == 3'h0) s.d = fcd_pkg::D_PROG;
      fcd_pkg::CMD_BYP_EXIT: s.d = (i == 3'h0) ? fcd_pkg::D_AUTOSEL : fcd_pkg::D_BYP_EXIT;
      default: begin
        if (i == 3'h0 || i == 3'h3) s = '{1'b0, {hi, fcd_pkg::A_UNLK1}, fcd_pkg::D_UNLK1};
        if (i == 3'h1 || i == 3'h4) s = '{1'b0, {hi, fcd_pkg::A_UNLK2}, fcd_pkg::D_UNLK2};
        if (i == 3'h2) begin
          s.a = {hi, fcd_pkg::A_UNLK1};
          unique case (r.cmd)
            fcd_pkg::CMD_PROG:      s.d = fcd_pkg::D_PROG;
            fcd_pkg::CMD_BYP_ENTER: s.d = fcd_pkg::D_BYP;
            fcd_pkg::CMD_SERASE,
            fcd_pkg::CMD_BERASE:    s.d = fcd_pkg::D_ERASE;
            default:                s.d = fcd_pkg::D_AUTOSEL;
          endcase
        end
        if (r.cmd inside {fcd_pkg::CMD_ID, fcd_pkg::CMD_PROT}) begin
          if (i == 3'h3)
            s = '{1'b1, {hi, (r.cmd == fcd_pkg::CMD_ID) ? fcd_pkg::A_ID : fcd_pkg::A_PROT},
                  8'h00};
          if (i == 3'h4) s = '{1'b0, {hi, fcd_pkg::A_UNLK1}, fcd_pkg::D_RESET};
        end
        if (r.cmd == fcd_pkg::CMD_PROG && i == 3'h3) s = '{1'b0, r.addr, r.data};
        if (i == fcd_pkg::STEP_ADD && r.cmd == fcd_pkg::CMD_SERASE)
          s = '{1'b0, r.addr, fcd_pkg::D_SECT};
        else if (i == fcd_pkg::STEP_ADD)
          s = '{1'b0, {hi, fcd_pkg::A_UNLK1}, fcd_pkg::D_BULK};
      end
    endcase
    return s;
  endfunction

  assign st      = fstep(rq_reg, step_reg);
  assign cur_sel = lowbit(mask_reg);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      rq_reg    <= '0;
      step_reg  <= 3'h0;
      cnt_reg   <= 4'h0;
      mask_reg  <= 8'h00;
      err       <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: if (req_valid) begin
          rq_reg   <= req;
          step_reg <= 3'h0;
          mask_reg <= req.arr ? {4'h0, req.sel[3:0]} : req.sel;
          // refuse secondary identifier or no select
          err       <= refused(req);
          state_reg <= refused(req) ? S_DONE : S_SETUP;
        end
        S_SETUP: begin
          cnt_reg   <= 4'h0;
          state_reg <= S_STRB;
        end
        S_STRB: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == fcd_pkg::STRB_CYC - 4'h1) state_reg <= S_HOLD;
        end
        S_HOLD: begin
          cnt_reg <= 4'h0;
          if (rq_reg.cmd == fcd_pkg::CMD_SERASE && step_reg == fcd_pkg::STEP_ADD &&
              (mask_reg & ~cur_sel) != 8'h00) begin
            mask_reg  <= mask_reg & ~cur_sel;
            state_reg <= S_SETUP;
          end else if (step_reg == last_idx(rq_reg.cmd)) begin
            state_reg <= waits(rq_reg.cmd) ? S_SETTLE : S_DONE;
          end else begin
            step_reg  <= step_reg + 3'h1;
            state_reg <= S_SETUP;
          end
        end
        S_SETTLE: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == fcd_pkg::BUSY_SETTLE - 4'h1) state_reg <= S_WRDY;
        end
        S_WRDY: if (port_c_line_three) state_reg <= S_DONE;
        S_DONE: state_reg <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  always_comb begin
    pins_next = fcd_pkg::PINS_RST;
    if (state_reg inside {S_SETUP, S_STRB, S_HOLD}) begin
      pins_next.addr      = st.a;
      pins_next.dout      = st.d;
      pins_next.dout_oe_n = st.rd;
      pins_next.main_sector_selects      = rq_reg.arr ? 8'h00 : cur_sel;
      pins_next.secondary_sector_selects = rq_reg.arr ? cur_sel[3:0] : 4'h0;
      // strobe framed by stable address and data
      pins_next.control_line_zero_n = !(state_reg == S_STRB && !st.rd);
      pins_next.rd_n                = !(state_reg == S_STRB && st.rd);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pins <= fcd_pkg::PINS_RST;
    else       pins <= pins_next;
  end

  // ---------------------------------------------------------------
  // Status toward the user
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata     <= 8'h00;
      done      <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      done      <= state_reg == S_DONE;
      req_ready <= state_reg == S_IDLE && !req_valid || state_reg == S_DONE;
      if (state_reg == S_HOLD && st.rd) rdata <= data_in;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [15:0] gap_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) gap_reg <= 16'h0000;
    else if ($rose(pins.control_line_zero_n)) gap_reg <= 16'h0000;
    else if (gap_reg != 16'hFFFF) gap_reg <= gap_reg + 16'h0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wr_fall;
    $fell(pins.control_line_zero_n);
  endsequence
  sequence s_strobe_pulse;
    (!pins.control_line_zero_n)[*2] ##1 pins.control_line_zero_n;
  endsequence

  property p_unlock1;
    s_wr_fall and ##0 (step_reg == 3'h0 && last_idx(rq_reg.cmd) >= 3'h2)
      |-> pins.addr[11:0] == 12'h555 && pins.dout == 8'hAA;
  endproperty
  a_unlock1: assert property (p_unlock1) else $error("first unlock wrong");

  property p_unlock2;
    s_wr_fall and ##0 (step_reg == 3'h1 && last_idx(rq_reg.cmd) >= 3'h2)
      |-> pins.addr[11:0] == 12'hAAA && pins.dout == 8'h55;
  endproperty
  a_unlock2: assert property (p_unlock2) else $error("second unlock wrong");

  property p_strobe;
    s_wr_fall |-> s_strobe_pulse;
  endproperty
  a_strobe: assert property (p_strobe) else $error("write strobe width wrong");

  property p_data_hold;
    $rose(pins.control_line_zero_n) |-> $stable(pins.dout) && $stable(pins.addr)
                                         && !pins.dout_oe_n;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved at strobe rise");

  property p_sel_onehot;
    !pins.control_line_zero_n |-> $onehot({pins.main_sector_selects,
                                            pins.secondary_sector_selects});
  endproperty
  a_sel_onehot: assert property (p_sel_onehot) else $error("sector select not single");

  property p_gap;
    s_wr_fall and ##0 (rq_reg.cmd == fcd_pkg::CMD_SERASE && step_reg == 3'h5)
      |-> gap_reg < ADD_GAP_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("extra sector byte too late");

  property p_reset_after_read;
    $rose(pins.rd_n) && rq_reg.cmd inside {fcd_pkg::CMD_ID, fcd_pkg::CMD_PROT}
      |-> ##[1:4] ($fell(pins.control_line_zero_n) && pins.dout == 8'hF0);
  endproperty
  a_reset_after_read: assert property (p_reset_after_read) else $error("no reset");

  property p_done_ready;
    done && waits(rq_reg.cmd) && !err |-> $past(port_c_line_three);
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("done before ready");

  property p_id_main;
    $fell(pins.rd_n) && rq_reg.cmd == fcd_pkg::CMD_ID |-> pins.secondary_sector_selects == 4'h0;
  endproperty
  a_id_main: assert property (p_id_main) else $error("identifier on secondary");

  property p_prog_data;
    s_wr_fall and ##0 (rq_reg.cmd == fcd_pkg::CMD_PROG && step_reg == 3'h3)
      |-> pins.addr == rq_reg.addr && pins.dout == rq_reg.data;
  endproperty
  a_prog_data: assert property (p_prog_data) else $error("program data wrong");

  property p_bulk_byte;
    s_wr_fall and ##0 (rq_reg.cmd == fcd_pkg::CMD_BERASE && step_reg == 3'h5)
      |-> pins.addr[11:0] == fcd_pkg::A_UNLK1 && pins.dout == fcd_pkg::D_BULK;
  endproperty
  a_bulk_byte: assert property (p_bulk_byte) else $error("bulk erase byte wrong");

  property p_suspend_byte;
    s_wr_fall and ##0 (rq_reg.cmd == fcd_pkg::CMD_SUSP)
      |-> pins.dout == fcd_pkg::D_SUSP;
  endproperty
  a_suspend_byte: assert property (p_suspend_byte) else $error("suspend byte wrong");

endmodule // fcd_host

// ### rtl/fcd_pkg.sv
// Constants and types shared by the flash command host.
package fcd_pkg;
  // Array organisation.
  localparam int unsigned MAIN_SECTORS = 8;
  localparam int unsigned SEC_SECTORS  = 4;
  localparam int unsigned SEC_SECT_KB  = 8;
  // Timing.
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned ADD_GAP_US   = 80;
  localparam int unsigned ADD_GAP_CYC  = ADD_GAP_US * CLK_MHZ;
  localparam logic [3:0]  STRB_CYC     = 4'h2;
  localparam logic [3:0]  BUSY_SETTLE  = 4'h8;
  // Step indices.
  localparam logic [2:0]  STEP_ADD     = 3'h5;
  // Command data bytes.
  localparam logic [7:0]  D_UNLK1      = 8'hAA;
  localparam logic [7:0]  D_UNLK2      = 8'h55;
  localparam logic [7:0]  D_AUTOSEL    = 8'h90;
  localparam logic [7:0]  D_PROG       = 8'hA0;
  localparam logic [7:0]  D_ERASE      = 8'h80;
  localparam logic [7:0]  D_SECT       = 8'h30;
  localparam logic [7:0]  D_BULK       = 8'h10;
  localparam logic [7:0]  D_SUSP       = 8'hB0;
  localparam logic [7:0]  D_RESET      = 8'hF0;
  localparam logic [7:0]  D_BYP        = 8'h20;
  localparam logic [7:0]  D_BYP_EXIT   = 8'h00;
  // Command addresses, low twelve bits.
  localparam logic [11:0] A_UNLK1      = 12'h555;
  localparam logic [11:0] A_UNLK2      = 12'hAAA;
  localparam logic [11:0] A_ID         = 12'h001;
  localparam logic [11:0] A_PROT       = 12'h002;

  typedef enum logic [3:0] {
    CMD_READ, CMD_ID, CMD_PROT, CMD_PROG, CMD_SERASE, CMD_BERASE,
    CMD_SUSP, CMD_RESUME, CMD_RESET, CMD_BYP_ENTER, CMD_BYP_PROG, CMD_BYP_EXIT
  } fcd_cmd_t;

  typedef struct packed {
    fcd_cmd_t    cmd;
    logic        arr;
    logic [7:0]  sel;
    logic [15:0] addr;
    logic [7:0]  data;
  } fcd_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        dout_oe_n;
    logic        control_line_zero_n;
    logic        rd_n;
    logic [7:0]  main_sector_selects;
    logic [3:0]  secondary_sector_selects;
  } fcd_pins_t;

  typedef struct packed {
    logic        rd;
    logic [15:0] a;
    logic [7:0]  d;
  } fcd_step_t;

  localparam fcd_pins_t PINS_RST = '{addr: 16'h0000, dout: 8'h00, dout_oe_n: 1'b1,
                                     control_line_zero_n: 1'b1, rd_n: 1'b1,
                                     main_sector_selects: 8'h00,
                                     secondary_sector_selects: 4'h0};
endpackage

// ### tb/fcd_flash_model.sv
// Behavioural flash device answering the host pins.
`timescale 1ns/100ps
module fcd_flash_model #(
  parameter int unsigned GAP_CYC   = 16,
  parameter logic [7:0]  ID_CODE   = 8'h3C, // Arbitrary value.
  parameter logic [7:0]  PROT_MAIN = 8'h04,
  parameter logic [3:0]  PROT_SEC  = 4'h2
) (
  input  wire logic               clk,
  input  wire fcd_pkg::fcd_pins_t pins,
  output      logic [7:0]         data_in,
  output      logic               ready
);
  logic [7:0]  mem [8];
  logic [15:0] wa;
  logic        strb_q, autosel, byp, ers, susp, prot, sec, any;
  logic [3:0]  step;
  logic [2:0]  sect;
  logic [7:0]  last, rd_val, d;
  logic [11:0] a;
  int          busy, gap;

  function automatic logic [2:0] lowest(input logic [7:0] s);
    lowest = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (s[i]) lowest = i[2:0];
    end
  endfunction

  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {strb_q, autosel, byp, ers, susp} = 5'h1F;
    {autosel, byp, ers, susp} = 4'h0;
    {step, busy, gap, last, wa} = '0;
  end

  // upper address ignored, array from selects.
  assign a    = wa[11:0];
  assign d    = pins.dout;
  assign sec  = |pins.secondary_sector_selects;
  assign any  = |pins.main_sector_selects | sec;
  assign sect = lowest(pins.main_sector_selects);
  assign prot = |(pins.main_sector_selects & PROT_MAIN) | |(pins.secondary_sector_selects & PROT_SEC);
  // busy while working, ready while suspended.
  assign ready = (busy == 0) || susp;

  always_comb begin
    rd_val = sec ? 8'hFF : mem[sect];
    if (autosel && pins.addr[11:0] == fcd_pkg::A_ID && !sec) rd_val = ID_CODE;
    if (autosel && pins.addr[11:0] == fcd_pkg::A_PROT) rd_val = {7'h00, prot};
  end
  // Released data bus shows the inverse of the last byte.
  assign data_in = pins.rd_n ? ~last : rd_val;

  always @(posedge clk) begin
    strb_q <= pins.control_line_zero_n;
    gap    <= gap + 1;
    if (!pins.rd_n) last <= rd_val;
    if (busy > 0 && !susp) busy <= busy - 1;
    if (busy == 0) ers <= 1'b0;
    if (gap > GAP_CYC) step <= 4'h0;
    if (strb_q && !pins.control_line_zero_n) wa <= pins.addr;
    if (!strb_q && pins.control_line_zero_n && any) begin
      gap  <= 0;
      step <= 4'h0;
      case (step)
        4'h0: begin
          if (d == fcd_pkg::D_UNLK1 && a == fcd_pkg::A_UNLK1) step <= 4'h1;
          if (d == fcd_pkg::D_RESET) autosel <= 1'b0;
          if (d == fcd_pkg::D_SUSP && ers) susp <= 1'b1;
          if (d == fcd_pkg::D_SECT && susp) susp <= 1'b0;
          if (byp && d == fcd_pkg::D_PROG) step <= 4'h7;
          if (byp && d == fcd_pkg::D_AUTOSEL) step <= 4'h8;
        end
        4'h1, 4'h5: begin
          if (d == fcd_pkg::D_UNLK2 && a == fcd_pkg::A_UNLK2) step <= step + 4'h1;
        end
        4'h2: begin
          if (a == fcd_pkg::A_UNLK1 && d == fcd_pkg::D_AUTOSEL) autosel <= 1'b1;
          if (a == fcd_pkg::A_UNLK1 && d == fcd_pkg::D_PROG) step <= 4'h3;
          if (a == fcd_pkg::A_UNLK1 && d == fcd_pkg::D_ERASE) step <= 4'h3 + 4'h1;
          if (a == fcd_pkg::A_UNLK1 && d == fcd_pkg::D_BYP) byp <= 1'b1;
        end
        4'h3, 4'h7: begin
          busy <= 20;
          if (!sec && !prot) mem[sect] <= mem[sect] & d;
        end
        4'h4: begin
          if (d == fcd_pkg::D_UNLK1 && a == fcd_pkg::A_UNLK1) step <= 4'h5;
        end
        4'h6: begin
          if (d == fcd_pkg::D_SECT) begin
            step <= 4'h6;
            busy <= 40;
            ers  <= 1'b1;
            if (!sec && !prot) mem[sect] <= 8'hFF;
          end
          if (d == fcd_pkg::D_BULK && a == fcd_pkg::A_UNLK1) begin
            busy <= 40;
            for (int i = 0; i < 8; i++) begin
              if (!sec && !PROT_MAIN[i]) mem[i] <= 8'hFF;
            end
          end
        end
        4'h8: begin
          if (d == fcd_pkg::D_BYP_EXIT) byp <= 1'b0;
        end
        default: step <= 4'h0;
      endcase
    end
  end
endmodule // fcd_flash_model

// ### tb/fcd_host_tb_top.sv
// Self-checking bench for the flash command host.
`timescale 1ns/100ps
module fcd_host_tb_top;
  typedef struct packed {
    fcd_pkg::fcd_req_t r;
    logic              e_err;
    logic              chk;
    logic [7:0]        e_rd;
  } fcd_row_t;
  localparam logic [7:0] ID_CODE = 8'h3C; // Arbitrary value.
  logic               clk, rstn, req_valid, req_ready, done, err, ready, saw_busy;
  logic [7:0]         rdata, data_in;
  fcd_pkg::fcd_req_t  req;
  fcd_pkg::fcd_pins_t pins;
  fcd_row_t           rows [22];
  int                 fails, n_compared;

  fcd_host #(.ADD_GAP_CYC(16)) u_dut (.clk(clk), .rstn(rstn), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .done(done), .err(err), .rdata(rdata),
    .pins(pins), .data_in(data_in), .port_c_line_three(ready));
  fcd_flash_model #(.GAP_CYC(16), .ID_CODE(ID_CODE)) u_flash (.clk(clk), .pins(pins),
    .data_in(data_in), .ready(ready));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic fcd_row_t mk(fcd_pkg::fcd_cmd_t c, logic a, logic [7:0] s,
                                  logic [7:0] d, logic e, logic k, logic [7:0] x);
    mk = '{r: '{cmd: c, arr: a, sel: s, addr: 16'hA000, data: d}, e_err: e, chk: k, e_rd: x};
  endfunction

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic issue(input fcd_pkg::fcd_req_t r);
    logic seen;
    int   n;
    req       = r;
    req_valid = 1'b1;
    seen      = 1'b0;
    for (n = 0; n < 4000 && !seen; n++) begin
      seen = (req_ready === 1'b1);
      @(negedge clk);
    end
    req_valid = 1'b0;
    for (n = 0; n < 4000 && done !== 1'b1; n++) begin
      @(negedge clk);
    end
    check(done, 1'b1);
  endtask

  always @(negedge clk) begin
    if (ready === 1'b0) saw_busy = 1'b1;
    if (pins.control_line_zero_n === 1'b0) check(pins.dout_oe_n, 1'b0);
  end

  initial begin
    #200000;
    fails++;
    conclude();
  end

  initial begin
    rows = '{mk(fcd_pkg::CMD_PROT, 0, 8'h04, 8'h00, 0, 1, 8'h01),
             mk(fcd_pkg::CMD_PROT, 0, 8'h01, 8'h00, 0, 1, 8'h00),
             mk(fcd_pkg::CMD_PROT, 1, 8'h02, 8'h00, 0, 1, 8'h01),
             mk(fcd_pkg::CMD_ID, 0, 8'h01, 8'h00, 0, 1, ID_CODE),
             mk(fcd_pkg::CMD_ID, 1, 8'h01, 8'h00, 1, 0, 8'h00),
             mk(fcd_pkg::CMD_READ, 0, 8'h00, 8'h00, 1, 0, 8'h00),
             mk(fcd_pkg::CMD_READ, 0, 8'h01, 8'h00, 0, 1, 8'hFF),
             mk(fcd_pkg::CMD_PROG, 0, 8'h01, 8'h5A, 0, 0, 8'h00),
             mk(fcd_pkg::CMD_READ, 0, 8'h01, 8'h00, 0, 1, 8'h5A),
             mk(fcd_pkg::CMD_PROG, 0, 8'h04, 8'h00, 0, 0, 8'h00),
             mk(fcd_pkg::CMD_READ, 0, 8'h04, 8'h00, 0, 1, 8'hFF),
             mk(fcd_pkg::CMD_SERASE, 0, 8'h05, 8'h00, 0, 0, 8'h00),
             mk(fcd_pkg::CMD_READ, 0, 8'h01, 8'h00, 0, 1, 8'hFF),
             mk(fcd_pkg::CMD_BYP_ENTER, 0, 8'h02, 8'h00, 0, 0, 8'h00),
             mk(fcd_pkg::CMD_BYP_PROG, 0, 8'h02, 8'h33, 0, 0, 8'h00),
             mk(fcd_pkg::CMD_BYP_EXIT, 0, 8'h02, 8'h00, 0, 0, 8'h00),
             mk(fcd_pkg::CMD_BYP_PROG, 0, 8'h02, 8'h00, 0, 0, 8'h00),
             mk(fcd_pkg::CMD_READ, 0, 8'h02, 8'h00, 0, 1, 8'h33),
             mk(fcd_pkg::CMD_BERASE, 0, 8'h02, 8'h00, 0, 0, 8'h00),
             mk(fcd_pkg::CMD_READ, 0, 8'h02, 8'h00, 0, 1, 8'hFF),
             mk(fcd_pkg::CMD_SUSP, 0, 8'h01, 8'h00, 0, 0, 8'h00),
             mk(fcd_pkg::CMD_RESUME, 0, 8'h01, 8'h00, 0, 0, 8'h00)};
    {rstn, req_valid, saw_busy, fails, n_compared} = '0;
    req = '0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 22; i++) begin
      issue(rows[i].r);
      check(err, rows[i].e_err);
      if (rows[i].chk) check(rdata, rows[i].e_rd);
      check(ready, 1'b1);
    end
    issue('{cmd: fcd_pkg::CMD_RESET, arr: 1'b0, sel: 8'h01, addr: 16'hA000, data: 8'h00});
    check(err, 1'b0);
    check(saw_busy, 1'b1);
    issue('{cmd: fcd_pkg::CMD_PROG, arr: 1'b1, sel: 8'h10, addr: 16'hA000, data: 8'h00});
    check(err, 1'b1);
    rstn = 1'b0;
    #1;
    check(pins, fcd_pkg::PINS_RST);
    check(req_ready, 1'b0);
    @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    check(req_ready, 1'b1);
    issue(rows[0].r);
    check(rdata, 8'h01);
    conclude();
  end
endmodule // fcd_host_tb_top
